// [eisf_pkg.sv]
// eisf_pkg: constants, states and request carrier of the serial memory front end
// assumes nothing beyond a SystemVerilog compiler; imported whole by every module but eisf_master
`default_nettype none

package eisf_pkg;

    // array geometry
    localparam int unsigned ADDR_W        = 9;
    localparam int unsigned PAGE_W        = 4;
    localparam logic [8:0]  ADDR_ONE      = 9'h001;

    // select byte layout
    localparam int unsigned BYTE_MSB      = 7;
    localparam int unsigned SEL_TYPE_MSB  = 7;
    localparam int unsigned SEL_TYPE_LSB  = 4;
    localparam int unsigned SEL_STRAP_HI  = 3;
    localparam int unsigned SEL_STRAP_LO  = 2;
    localparam int unsigned SEL_MSB_BIT   = 1;
    localparam int unsigned SEL_RW_BIT    = 0;
    localparam logic [3:0]  TYPE_MEM      = 4'ha;
    localparam logic [3:0]  TYPE_ID       = 4'hb;

    // address and data byte fields
    localparam int unsigned ADR_LOCK_BIT  = 7;
    localparam int unsigned LOCK_DATA_BIT = 1;

    // bit counter within a byte frame
    localparam logic [3:0]  CNT_ZERO      = 4'h0;
    localparam logic [3:0]  CNT_ONE       = 4'h1;
    localparam logic [3:0]  CNT_LAST      = 4'h7;
    localparam logic [3:0]  CNT_ACK       = 4'h8;
    localparam logic [3:0]  CNT_ACK_DONE  = 4'h9;

    // synchroniser lanes
    localparam int unsigned SYNC_W        = 6;
    localparam int unsigned SY_SCL        = 0;
    localparam int unsigned SY_SDA        = 1;
    localparam int unsigned SY_E2         = 2;
    localparam int unsigned SY_E1         = 3;
    localparam int unsigned SY_WP         = 4;
    localparam int unsigned SY_TOG        = 5;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } eisf_state_e;

    typedef struct packed {
        logic              id;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } eisf_req_s;

endpackage : eisf_pkg

`default_nettype wire

// [eisf_sync.sv]
// eisf_sync: two flip-flop synchroniser, one lane per bit
// assumes each lane is a level that holds far longer than two clock periods
`default_nettype none

module eisf_sync
    import eisf_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // lanes
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("eisf_sync needs at least one lane");
    end

    // meta_r feeds q_o only
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_r <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule : eisf_sync

`default_nettype wire

// [eisf_link_rx.sv]
// eisf_link_rx: samples the data line on each rising serial clock edge
// assumes the master keeps data stable across the edge; reset is asynchronous
`default_nettype none

module eisf_link_rx
    import eisf_pkg::*;
(
    // link clock and reset
    input  wire logic scl_i,
    input  wire logic rstn_i,
    // data pin
    input  wire logic sda_i,
    // sampled bit and its event toggle
    output logic      bit_o,
    output logic      tog_o
);

    // bit_o holds a full clock period, so the toggle alone needs synchronising
    always_ff @(posedge scl_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bit_o <= 1'b1;
            tog_o <= 1'b0;
        end
        else
        begin
            bit_o <= sda_i;
            tog_o <= ~tog_o;
        end
    end

endmodule : eisf_link_rx

`default_nettype wire

// [eisf_front.sv]
// eisf_front: slave front end of a small serial memory, link bits to byte requests
// assumes CLK_I far faster than the serial clock; write engine and array outside
// What this block does
// - start is data fall while clock high
// - ignore starts during internal write cycle
// - stop is data rise while clock high
// - stop after write data launches write cycle
// - sample data on rising serial clock edge
// - receiver pulls data low in ninth pulse
// - only types 1010b and 1011b are acknowledged
// - select strap bits must equal pin levels
// - unconnected strap pin must be pulled to zero outside the block
// - select bit zero is read/write direction
// - main array takes bit one as address_msb
// - mismatch releases bus until next start
// - matching select and address byte acknowledged
// - protect high refuses data bytes only
// - protect low allows writes; an open protect pin must be pulled low outside the block
// - main array is nine address bits
// - page access uses low four address bits
// - device is slave, never drives clock
// - page_lock_command needs b7 and data bit1
// - locked page refuses page write data
// - write cycle keeps data pin released
// - write address wraps inside sixteen bytes
`default_nettype none

module eisf_front
    import eisf_pkg::*;
(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    // serial link, clock only ever read
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_O,
    // straps and protection
    input  wire logic       CHIP_SEL_STRAP_HIGH_I,
    input  wire logic       CHIP_SEL_STRAP_LOW_I,
    input  wire logic       WRITE_PROTECT_INPUT_I,
    // array side
    input  wire logic       WR_BUSY_I,
    input  wire logic       ID_LOCKED_I,
    input  wire logic [7:0] RD_DATA_I,
    output var eisf_req_s   REQ_O,
    output logic            WR_STB_O,
    output logic            RD_STB_O,
    output logic            WR_GO_O,
    output logic            LOCK_GO_O,
    output logic            ACTIVE_O
);

    function automatic logic type_ok(input logic [7:0] b);
        type_ok = (b[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_MEM) ||
                  (b[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID);
    endfunction : type_ok

    function automatic logic sel_ok(input logic [7:0] b, input logic e2, input logic e1);
        sel_ok = type_ok(b) && (b[SEL_STRAP_HI] == e2) && (b[SEL_STRAP_LO] == e1);
    endfunction : sel_ok

    function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a,
                                                   input logic              page_wrap);
        logic [ADDR_W-1:0] full;
        full     = a + ADDR_ONE;
        addr_inc = page_wrap ? {a[ADDR_W-1:PAGE_W], full[PAGE_W-1:0]} : full;
    endfunction : addr_inc

    logic [SYNC_W-1:0] sync_d;
    logic [SYNC_W-1:0] sync_q;
    logic              link_bit;
    logic              link_tog;
    logic              scl_q_r;
    logic              sda_q_r;
    logic              tog_q_r;
    eisf_state_e       state_r;
    logic [3:0]        cnt_r;
    logic [7:0]        shift_r;
    logic [7:0]        tx_r;
    logic [ADDR_W-1:0] addr_r;
    logic              ack_r;
    logic              ack_nxt;
    logic              id_r;
    logic              lock_r;
    logic              pend_wr_r;
    logic              pend_lock_r;
    logic              sda_o_r;
    logic              sda_oe_r;
    eisf_req_s         req_r;
    logic              wr_stb_r;
    logic              rd_stb_r;
    logic              wr_go_r;
    logic              lock_go_r;
    logic              active_r;

    eisf_link_rx u_link (
        .scl_i  (SCL_I),
        .rstn_i (RSTN_I),
        .sda_i  (SDA_I),
        .bit_o  (link_bit),
        .tog_o  (link_tog)
    );

    // an open strap pin must be pulled to zero outside the core
    assign sync_d = {link_tog, WRITE_PROTECT_INPUT_I, CHIP_SEL_STRAP_LOW_I,
                     CHIP_SEL_STRAP_HIGH_I, SDA_I, SCL_I};

    eisf_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .d_i    (sync_d),
        .q_o    (sync_q)
    );

    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic       start_ev;
    logic       stop_ev;
    logic       scl_fall;
    logic       bit_ev;
    logic       in_frame;
    logic       byte_done;
    logic       mack_ev;
    logic       sel_hit;
    logic [7:0] byte_w;
    logic [3:0] sel_type;

    assign scl_s     = sync_q[SY_SCL];
    assign sda_s     = sync_q[SY_SDA];
    assign wp_s      = sync_q[SY_WP];
    assign start_ev  = scl_s && scl_q_r && sda_q_r && !sda_s;
    assign stop_ev   = scl_s && scl_q_r && !sda_q_r && sda_s;
    assign scl_fall  = scl_q_r && !scl_s;
    assign bit_ev    = sync_q[SY_TOG] ^ tog_q_r;
    assign in_frame  = (state_r != ST_IDLE) && (state_r != ST_IGNORE);
    assign byte_w    = {shift_r[BYTE_MSB-1:0], link_bit};
    assign byte_done = bit_ev && in_frame && (cnt_r == CNT_LAST);
    // a read select's own ack slot still has ack_r set, so it is no master ack
    assign mack_ev   = bit_ev && (state_r == ST_RDATA) && (cnt_r == CNT_ACK) && !ack_r;
    assign sel_type  = byte_w[SEL_TYPE_MSB:SEL_TYPE_LSB];
    // straps read at every select, not latched once
    assign sel_hit   = sel_ok(byte_w, sync_q[SY_E2], sync_q[SY_E1]);

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            scl_q_r <= 1'b0;
            sda_q_r <= 1'b0;
            tog_q_r <= 1'b0;
        end
        else
        begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
            tog_q_r <= sync_q[SY_TOG];
        end
    end

    always_comb
    begin
        case (state_r)
            ST_DEV:   ack_nxt = sel_hit;
            ST_ADDR:  ack_nxt = 1'b1;
            ST_WDATA: ack_nxt = !wp_s && !(id_r && ID_LOCKED_I) &&
                                (!lock_r || byte_w[LOCK_DATA_BIT]);
            default:  ack_nxt = 1'b0;
        endcase
    end

    // frame sequencing
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
            shift_r <= '0;
        end
        else if (WR_BUSY_I)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
        end
        else if (start_ev)
        begin
            state_r <= ST_DEV;
            cnt_r   <= CNT_ZERO;
        end
        else if (stop_ev)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
        end
        else if (bit_ev && in_frame)
        begin
            shift_r <= byte_w;
            cnt_r   <= (cnt_r == CNT_ACK_DONE) ? cnt_r : cnt_r + CNT_ONE;
            if (byte_done && state_r == ST_DEV)
            begin
                if (!sel_hit)
                    state_r <= ST_IGNORE;
                else if (byte_w[SEL_RW_BIT])
                    state_r <= ST_RDATA;
                else
                    state_r <= ST_ADDR;
            end
            else if (byte_done && state_r == ST_ADDR)
                state_r <= ST_WDATA;
            else if (mack_ev && link_bit)
                state_r <= ST_IGNORE;
        end
        else if (scl_fall && cnt_r == CNT_ACK_DONE)
            cnt_r <= CNT_ZERO;
    end

    // address pointer, acknowledge decision, pending commands
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ack_r       <= 1'b0;
            id_r        <= 1'b0;
            lock_r      <= 1'b0;
            addr_r      <= '0;
            pend_wr_r   <= 1'b0;
            pend_lock_r <= 1'b0;
        end
        else if (WR_BUSY_I || start_ev || stop_ev)
        begin
            ack_r       <= 1'b0;
            lock_r      <= 1'b0;
            pend_wr_r   <= 1'b0;
            pend_lock_r <= 1'b0;
        end
        else if (byte_done)
        begin
            ack_r <= ack_nxt;
            case (state_r)
                ST_DEV:
                begin
                    if (sel_hit)
                        id_r <= (sel_type == TYPE_ID);
                    if (sel_hit && sel_type == TYPE_MEM)
                        addr_r[ADDR_W-1] <= byte_w[SEL_MSB_BIT];
                end
                ST_ADDR:
                begin
                    if (id_r)
                    begin
                        lock_r                <= byte_w[ADR_LOCK_BIT];
                        addr_r[PAGE_W-1:0]    <= byte_w[PAGE_W-1:0];
                    end
                    else
                        addr_r[ADDR_W-2:0]    <= byte_w;
                end
                ST_WDATA:
                begin
                    if (ack_nxt && lock_r)
                        pend_lock_r <= 1'b1;
                    else if (ack_nxt)
                    begin
                        pend_wr_r <= 1'b1;
                        addr_r    <= addr_inc(addr_r, 1'b1);
                    end
                end
                default:
                begin
                    ack_r <= 1'b0;
                end
            endcase
        end
        else if (mack_ev)
            addr_r <= addr_inc(addr_r, id_r);
    end

    // open-drain data pin, driven low only after a falling clock; busy, start and stop release it
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            sda_o_r  <= 1'b0;
            sda_oe_r <= 1'b0;
            tx_r     <= '0;
        end
        else if (WR_BUSY_I || start_ev || stop_ev || !in_frame)
            sda_oe_r <= 1'b0;
        else if (scl_fall)
        begin
            if (cnt_r == CNT_ACK)
                sda_oe_r <= ack_r;
            else if (cnt_r == CNT_ACK_DONE && state_r == ST_RDATA)
            begin
                tx_r     <= RD_DATA_I;
                sda_oe_r <= !RD_DATA_I[BYTE_MSB];
            end
            else if (cnt_r == CNT_ACK_DONE)
                sda_oe_r <= 1'b0;
            else if (state_r == ST_RDATA && cnt_r != CNT_ZERO)
            begin
                tx_r     <= {tx_r[BYTE_MSB-1:0], 1'b0};
                sda_oe_r <= !tx_r[BYTE_MSB-1];
            end
        end
    end

    // requests towards the array and the write engine
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            req_r     <= '0;
            wr_stb_r  <= 1'b0;
            rd_stb_r  <= 1'b0;
            wr_go_r   <= 1'b0;
            lock_go_r <= 1'b0;
            active_r  <= 1'b0;
        end
        else
        begin
            wr_stb_r  <= byte_done && state_r == ST_WDATA && ack_nxt && !lock_r;
            rd_stb_r  <= (byte_done && state_r == ST_DEV && sel_hit && byte_w[SEL_RW_BIT]) ||
                         (mack_ev && !link_bit);
            // a stop always follows the clock rise of the tenth slot, counted as one bit
            wr_go_r   <= stop_ev && !WR_BUSY_I && state_r == ST_WDATA &&
                         cnt_r == CNT_ONE && pend_wr_r;
            lock_go_r <= stop_ev && !WR_BUSY_I && state_r == ST_WDATA &&
                         cnt_r == CNT_ONE && pend_lock_r;
            active_r  <= in_frame;
            if (byte_done && state_r == ST_WDATA && ack_nxt && !lock_r)
                req_r <= '{id: id_r, addr: addr_r, data: byte_w};
            else if (byte_done && state_r == ST_DEV && sel_hit && sel_type == TYPE_MEM)
                req_r <= '{id: 1'b0, addr: {byte_w[SEL_MSB_BIT], addr_r[ADDR_W-2:0]},
                           data: 8'h00};
            else if (byte_done && state_r == ST_DEV && sel_hit)
                req_r <= '{id: 1'b1, addr: addr_r, data: 8'h00};
            else if (mack_ev)
                req_r <= '{id: id_r, addr: addr_inc(addr_r, id_r), data: 8'h00};
        end
    end

    // no clock output exists: the master owns every clock edge
    assign SDA_O     = sda_o_r;
    assign SDA_OE_O  = sda_oe_r;
    assign REQ_O     = req_r;
    assign WR_STB_O  = wr_stb_r;
    assign RD_STB_O  = rd_stb_r;
    assign WR_GO_O   = wr_go_r;
    assign LOCK_GO_O = lock_go_r;
    assign ACTIVE_O  = active_r;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    chk_busy_quiet: assert property (WR_BUSY_I |=> state_r == ST_IDLE && !SDA_OE_O)
        else $error("busy cycle left the front end active");
    chk_busy_start: assert property (WR_BUSY_I && start_ev |=> state_r != ST_DEV)
        else $error("start taken during write cycle");
    chk_start_frame: assert property (start_ev && !WR_BUSY_I |=>
                                      state_r == ST_DEV && cnt_r == CNT_ZERO)
        else $error("start did not open a select frame");
    chk_stop_ends: assert property (stop_ev |=> state_r == ST_IDLE ##1 !SDA_OE_O)
        else $error("stop did not end the frame");
    chk_write_launch: assert property (stop_ev && !WR_BUSY_I && state_r == ST_WDATA &&
                                       cnt_r == CNT_ONE && pend_wr_r |=> WR_GO_O ##1 !WR_GO_O)
        else $error("write cycle not launched once");
    chk_type_filter: assert property (byte_done && state_r == ST_DEV && !type_ok(byte_w)
                                      |=> state_r == ST_IGNORE && !ack_r)
        else $error("foreign type identifier accepted");
    chk_strap_match: assert property (byte_done && state_r == ST_DEV && type_ok(byte_w) &&
                                      byte_w[SEL_STRAP_HI] != sync_q[SY_E2] |=> !ack_r)
        else $error("strap mismatch acknowledged");
    chk_sel_ack: assert property (byte_done && state_r == ST_DEV && sel_hit |=> ack_r)
        else $error("matching select not acknowledged");
    chk_protect_nack: assert property (byte_done && state_r == ST_WDATA && wp_s
                                       |=> !ack_r && !WR_STB_O)
        else $error("protected data byte accepted");
    chk_page_wrap: assert property (WR_STB_O |->
                                    addr_r[ADDR_W-1:PAGE_W] == REQ_O.addr[ADDR_W-1:PAGE_W] &&
                                    addr_r[PAGE_W-1:0] == REQ_O.addr[PAGE_W-1:0] + CNT_ONE)
        else $error("write pointer left its page");
    chk_ack_drive: assert property (scl_fall && cnt_r == CNT_ACK && ack_r && in_frame &&
                                    !start_ev && !stop_ev && !WR_BUSY_I |=> SDA_OE_O)
        else $error("acknowledge not driven");

    cov_write_go: cover property (WR_GO_O);
    cov_read_fetch: cover property (RD_STB_O ##[1:1000] RD_STB_O);
    cov_lock_go: cover property (LOCK_GO_O);
    cov_ignore: cover property (state_r == ST_IGNORE);

endmodule : eisf_front

`default_nettype wire

// [eisf_master.sv]
// eisf_master: behavioural bus master on the serial link
// assumes a pull-up on the data line; paced by the link clock
`default_nettype none

module eisf_master
(
    // pacing tick
    input  wire logic clk_i,
    // resolved data line
    input  wire logic sda_i,
    // clock pin and data pull-down
    output logic      scl_o = 1'b1,
    output logic      pull_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tk

    // data moves mid-low, well away from both clock edges
    task automatic bit_io(input logic b, output logic s);
        pull_o <= !b;
        tk(2);
        scl_o <= 1'b1;
        tk(2);
        s = sda_i;
        tk(2);
        scl_o <= 1'b0;
        tk(2);
    endtask : bit_io

    // covers repeated start too; clock stands high between frames
    task automatic start();
        tk(1);
        if (!scl_o)
        begin
            pull_o <= 1'b0;
            tk(2);
            scl_o <= 1'b1;
        end
        tk(4);
        pull_o <= 1'b1;
        tk(4);
        scl_o <= 1'b0;
        tk(2);
    endtask : start

    task automatic stop();
        pull_o <= 1'b1;
        tk(2);
        scl_o <= 1'b1;
        tk(2);
        pull_o <= 1'b0;
        tk(4);
    endtask : stop

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] b, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(!ack, s);
    endtask : recv_byte
endmodule : eisf_master

`default_nettype wire

// [testbench.sv]
// testbench: front end against the bus master model and a small array stub
// assumes package, front end and master model are compiled first
`default_nettype none

`define EISF_CHK(nm, ex, got) \
begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
        fails++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
end

module testbench
    import eisf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       s_hi = 1'b1;
    logic       s_lo = 1'b0;
    logic       wp = 1'b0;
    logic       busy = 1'b0;
    logic       locked = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic       scl, pull, sda_o, sda_oe, wr_stb, rd_stb, wr_go, lock_go, active;
    eisf_req_s  req;
    eisf_req_s  wr_q[$];
    int         fails = 0;
    int         n_compared = 0;
    int         n_go = 0;
    int         n_lock = 0;
    int         go_exp = 0;
    int         lock_exp = 0;
    // pull-up: line low while either side pulls
    wire        sda = !(sda_oe | pull);

    eisf_front eisf_front_inst
    (
        .CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .CHIP_SEL_STRAP_HIGH_I(s_hi), .CHIP_SEL_STRAP_LOW_I(s_lo),
        .WRITE_PROTECT_INPUT_I(wp), .WR_BUSY_I(busy), .ID_LOCKED_I(locked),
        .RD_DATA_I(rd_data), .REQ_O(req), .WR_STB_O(wr_stb), .RD_STB_O(rd_stb),
        .WR_GO_O(wr_go), .LOCK_GO_O(lock_go), .ACTIVE_O(active)
    );
    eisf_master eisf_master_inst
    (
        .clk_i(link_clk), .sda_i(sda), .scl_o(scl), .pull_o(pull)
    );

    initial forever #2.5 clk = ~clk;
    // link pacing clock, phase unrelated to clk
    initial
    begin
        #7;
        forever #16 link_clk = ~link_clk;
    end

    // array stub: read byte is a fixed mix of the fetched address
    always @(posedge clk)
    begin
        if (wr_stb)
            wr_q.push_back(req);
        if (wr_go)
            n_go++;
        if (lock_go)
            n_lock++;
        if (rd_stb)
            rd_data <= req.addr[7:0] ^ 8'h3c;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic m_start();
        eisf_master_inst.start();
    endtask : m_start

    task automatic m_stop();
        eisf_master_inst.stop();
    endtask : m_stop

    task automatic xfer(input string nm, input logic [7:0] b, input logic exp);
        logic a;
        eisf_master_inst.send_byte(b, a);
        `EISF_CHK(nm, exp, a)
    endtask : xfer

    task automatic rx(input logic [7:0] exp, input logic ack);
        logic [7:0] d;
        eisf_master_inst.recv_byte(d, ack);
        `EISF_CHK("read byte", exp, d)
    endtask : rx

    // launch pulses trail the stop by a few cycles; bounded wait
    task automatic settle(input logic chk_go);
        int k;
        k = 0;
        while (k < 60 && ((chk_go && n_go != go_exp) || n_lock != lock_exp))
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 60)
        begin
            fails++;
            $display("[FAIL] pulses expected go %0d lock %0d", go_exp, lock_exp);
            end_sim();
        end
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic t_write();
        wr_q.delete();
        m_start();
        xfer("select", 8'haa, 1'b1);
        xfer("address", 8'h3f, 1'b1);
        xfer("data 0", 8'h11, 1'b1);
        xfer("data 1", 8'h22, 1'b1);
        m_stop();
        go_exp++;
        settle(1'b1);
        `EISF_CHK("write launch", go_exp, n_go)
        `EISF_CHK("write count", 2, wr_q.size())
        if (wr_q.size() == 2)
        begin
            `EISF_CHK("write 0", {1'b0, 9'h13f, 8'h11}, wr_q[0])
            `EISF_CHK("write 1", {1'b0, 9'h130, 8'h22}, wr_q[1])
        end
        $display("t_write done");
    endtask : t_write

    task automatic t_busy();
        @(posedge clk);
        busy <= 1'b1;
        m_start();
        xfer("busy select", 8'haa, 1'b0);
        m_stop();
        @(posedge clk);
        busy <= 1'b0;
        $display("t_busy done");
    endtask : t_busy

    task automatic t_sel();
        for (int t = 0; t < 16; t++)
        begin
            m_start();
            xfer("type", {t[3:0], 4'h8}, t == 10 || t == 11);
            xfer("next byte", 8'h00, t == 10 || t == 11);
            m_stop();
        end
        m_start();
        xfer("strap miss", 8'ha4, 1'b0);
        m_stop();
        @(posedge clk);
        s_hi <= 1'b0;
        m_start();
        xfer("strap zero", 8'ha0, 1'b1);
        m_stop();
        @(posedge clk);
        s_hi <= 1'b1;
        settle(1'b1);
        `EISF_CHK("no launch", go_exp, n_go)
        $display("t_sel done");
    endtask : t_sel

    task automatic t_prot();
        wr_q.delete();
        @(posedge clk);
        wp <= 1'b1;
        m_start();
        xfer("wp select", 8'haa, 1'b1);
        xfer("wp address", 8'h20, 1'b1);
        xfer("wp data", 8'h55, 1'b0);
        m_stop();
        @(posedge clk);
        wp <= 1'b0;
        settle(1'b1);
        `EISF_CHK("wp writes", 0, wr_q.size())
        $display("t_prot done");
    endtask : t_prot

    task automatic t_id();
        wr_q.delete();
        m_start();
        xfer("id select", 8'hb8, 1'b1);
        xfer("id address", 8'h75, 1'b1);
        xfer("id data", 8'h5a, 1'b1);
        m_stop();
        go_exp++;
        settle(1'b1);
        `EISF_CHK("id write", {1'b1, 4'h5, 8'h5a}, {req.id, req.addr[3:0], req.data})
        @(posedge clk);
        locked <= 1'b1;
        m_start();
        xfer("locked select", 8'hb8, 1'b1);
        xfer("locked address", 8'h02, 1'b1);
        xfer("locked data", 8'h33, 1'b0);
        m_stop();
        @(posedge clk);
        locked <= 1'b0;
        m_start();
        xfer("lock select", 8'hb8, 1'b1);
        xfer("lock address", 8'h80, 1'b1);
        xfer("lock data", 8'h02, 1'b1);
        m_stop();
        lock_exp++;
        settle(1'b0);
        `EISF_CHK("lock launch", lock_exp, n_lock)
        `EISF_CHK("no write on lock", go_exp, n_go)
        $display("t_id done");
    endtask : t_id

    task automatic t_read();
        m_start();
        xfer("rd select w", 8'haa, 1'b1);
        xfer("rd address", 8'h10, 1'b1);
        `EISF_CHK("active in frame", 1'b1, active)
        m_start();
        xfer("rd select r", 8'hab, 1'b1);
        rx(8'h10 ^ 8'h3c, 1'b1);
        rx(8'h11 ^ 8'h3c, 1'b0);
        m_stop();
        settle(1'b1);
        `EISF_CHK("active after stop", 1'b0, active)
        `EISF_CHK("data pin level", 1'b0, sda_o)
        $display("t_read done");
    endtask : t_read

    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_write();
        t_busy();
        t_sel();
        t_prot();
        t_id();
        t_read();
        end_sim();
    end

    initial
    begin
        #400us;
        fails++;
        $display("[FAIL] run did not finish in time");
        end_sim();
    end
endmodule : testbench

`default_nettype wire
